// File: hw/pedu_pkg.sv
package pedu_pkg;

    // ------------------------------------------------------------
    // Retry counters and qualifier values
    // ------------------------------------------------------------
    localparam logic [1:0] PIN_CNT_INIT = 2'h3;
    localparam logic [3:0] UNL_CNT_INIT = 4'ha;
    localparam logic [7:0] QUAL_USE = 8'h08;
    localparam logic [7:0] QUAL_NOUSE = 8'h00;

    // ------------------------------------------------------------
    // Command field coding
    // ------------------------------------------------------------
    localparam logic [7:0] LC_EMPTY = 8'h00;
    localparam logic [7:0] LC_PIN = 8'h08;
    localparam logic [7:0] LC_UNBLK = 8'h10;
    localparam int P1_ALT_BIT = 7;
    localparam int REF_MSB = 4;
    localparam int RFU_MSB = 6;
    localparam int RFU_LSB = 5;
    localparam int DATA_W = 128;
    localparam int KEY_W = 64;

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_REFUSED = 16'h6985;
    localparam logic [15:0] SW_BLOCKED = 16'h6983;
    localparam logic [15:0] SW_P1P2 = 16'h6a86;
    localparam logic [15:0] SW_LEN = 16'h6700;
    localparam logic [15:0] SW_INS = 16'h6d00;
    localparam logic [11:0] SW_RETRY = 12'h63c;

    // ------------------------------------------------------------
    // Register map, control bits, status fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SLOT = 8'h04;
    localparam logic [7:0] REG_VAL_HI = 8'h08;
    localparam logic [7:0] REG_VAL_LO = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_LAST_SW = 8'h14;
    localparam logic [7:0] REG_QUAL = 8'h18;
    localparam int CTRL_PERSO = 0;
    localparam int CTRL_LOAD_PIN = 1;
    localparam int CTRL_LOAD_UNL = 2;
    localparam int ST_PIN_CNT_LSB = 0;
    localparam int ST_UNL_CNT_LSB = 2;
    localparam int ST_EN_BIT = 6;
    localparam int ST_VER_BIT = 7;
    localparam int ST_ALT_BIT = 8;
    localparam int ST_ALTREF_LSB = 9;
    localparam logic [4:0] SLOT_RST = 5'h00;
    localparam logic [31:0] VAL_RST = 32'h0000_0000;
    localparam logic [15:0] LAST_SW_RST = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PEDU_INS_DISABLE,
        PEDU_INS_ENABLE,
        PEDU_INS_UNBLOCK,
        PEDU_INS_OTHER
    } pedu_ins_t;

    typedef struct packed {
        pedu_ins_t ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic [127:0] data;
    } pedu_cmd_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pedu_reg_req_t;

endpackage

// File: hw/pedu_core.sv
`timescale 1ns/1ns
// Behaviour
// - Correct disable: counter to 3, PIN disabled
// - Wrong disable: decrement counter, stay enabled
// - Third consecutive wrong presentation blocks PIN
// - Refuse disable when disabled or blocked
// - Refuse enable when enabled or blocked
// - Correct enable: counter to 3, PIN enabled
// - Wrong enable: decrement counter, stay disabled
// - Blocking during enable, optionally mark enabled
// - Blocked disabled PIN grants, blocked enabled denies
// - Disable P1: zero, or replacement key reference
// - Replacement key qualifier set to 08
// - Enable cancels replacement, qualifier to 00
// - Disabled PIN frees access or needs replacement
// - Unblock allowed unless unblock key blocked
// - Correct unblock: new PIN, counters reloaded
// - Wrong unblock key: decrement, answer 63C9..63C0
// - Tenth failure blocks key; later 6983
// - Wrong unblock key leaves PIN untouched
// - Empty unblock reports remaining retries 63CX
// - Empty unblock on blocked key gives 63C0
// - P2 selects reference, number 01 to 1F
module pedu_core #(
    parameter int NUM_SLOT = 4,
    parameter int SLOT_W = 2,
    parameter bit ENABLE_ON_BLOCK = 1'b0
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // Register port
    input wire pedu_pkg::pedu_reg_req_t REG_I,
    output logic [31:0] REG_RDATA_O,
    // Command frame in, status word out
    input wire logic CMD_VALID_I,
    input wire pedu_pkg::pedu_cmd_t CMD_I,
    output logic RSP_VALID_O,
    output logic [15:0] RSP_SW_O,
    // Access conditions per slot
    output logic [NUM_SLOT-1:0] ACCESS_OK_O,
    output logic [NUM_SLOT-1:0] ALT_REQ_O
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire [SLOT_W-1:0] slot = CMD_I.p2[SLOT_W-1:0];
    wire [4:0] p1_ref = CMD_I.p1[pedu_pkg::REF_MSB:0];
    wire [4:0] p2_ref = CMD_I.p2[pedu_pkg::REF_MSB:0];
    wire is_dis = CMD_I.ins == pedu_pkg::PEDU_INS_DISABLE;
    wire is_en = CMD_I.ins == pedu_pkg::PEDU_INS_ENABLE;
    wire is_unb = CMD_I.ins == pedu_pkg::PEDU_INS_UNBLOCK;
    wire p2_ok = CMD_I.p2[pedu_pkg::RFU_MSB:pedu_pkg::RFU_LSB] == 2'h0 && p2_ref != 5'h00;
    wire p1_alt = CMD_I.p1[pedu_pkg::P1_ALT_BIT];
    wire dis_p1_ok = CMD_I.p1 == 8'h00 || (p1_alt && p1_ref != 5'h00
                     && CMD_I.p1[pedu_pkg::RFU_MSB:pedu_pkg::RFU_LSB] == 2'h0);
    wire p1_ok = is_dis ? dis_p1_ok : CMD_I.p1 == 8'h00;
    wire lc_empty = CMD_I.lc == pedu_pkg::LC_EMPTY;
    wire lc_ok = is_unb ? (lc_empty || CMD_I.lc == pedu_pkg::LC_UNBLK)
                        : CMD_I.lc == pedu_pkg::LC_PIN;
    wire [63:0] key_in = CMD_I.data[pedu_pkg::DATA_W-1:pedu_pkg::KEY_W];
    wire [63:0] new_pin = CMD_I.data[pedu_pkg::KEY_W-1:0];

    // ------------------------------------------------------------
    // Per-slot views of retained storage
    // ------------------------------------------------------------
    logic [1:0] pin_cnt_w [NUM_SLOT];
    logic [3:0] unl_cnt_w [NUM_SLOT];
    logic en_w [NUM_SLOT];
    logic ver_w [NUM_SLOT];
    logic alt_on_w [NUM_SLOT];
    logic [4:0] alt_ref_w [NUM_SLOT];
    logic [63:0] pin_w [NUM_SLOT];
    logic [63:0] unl_w [NUM_SLOT];
    logic [7:0] qual_ff [32];

    wire [1:0] cur_pin_cnt = pin_cnt_w[slot];
    wire [3:0] cur_unl_cnt = unl_cnt_w[slot];
    wire cur_en = en_w[slot];
    wire cur_ver = ver_w[slot];
    wire cur_alt_on = alt_on_w[slot];
    wire [4:0] cur_alt_ref = alt_ref_w[slot];
    wire pin_blk = cur_pin_cnt == 2'h0;
    wire unl_blk = cur_unl_cnt == 4'h0;
    wire pin_match = key_in == pin_w[slot];
    wire unl_match = key_in == unl_w[slot];
    wire [1:0] dec_pin = cur_pin_cnt - 2'h1;
    wire [3:0] dec_unl = cur_unl_cnt - 4'h1;

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic [4:0] slot_sel_ff;
    logic [31:0] val_hi_ff;
    logic [31:0] val_lo_ff;
    logic [15:0] last_sw_ff;
    logic [31:0] rdata_ff;
    logic rsp_valid_ff;
    logic [15:0] rsp_sw_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] st_word;

    // Command wins a same-cycle control write; software must retry
    wire ctrl_wr = REG_I.wr && REG_I.addr == pedu_pkg::REG_CTRL && !CMD_VALID_I;
    wire perso = ctrl_wr && REG_I.wdata[pedu_pkg::CTRL_PERSO];
    wire load_pin = ctrl_wr && REG_I.wdata[pedu_pkg::CTRL_LOAD_PIN];
    wire load_unl = ctrl_wr && REG_I.wdata[pedu_pkg::CTRL_LOAD_UNL];
    wire [SLOT_W-1:0] reg_slot = slot_sel_ff[SLOT_W-1:0];
    wire [63:0] load_val = {val_hi_ff, val_lo_ff};

    // ------------------------------------------------------------
    // Command outcome
    // ------------------------------------------------------------
    logic [15:0] nxt_sw;
    logic we_pin_cnt, we_unl_cnt, we_en, we_pin_val, we_alt, we_qual, we_ver;
    logic [1:0] nxt_pin_cnt;
    logic [3:0] nxt_unl_cnt;
    logic nxt_en, nxt_alt_on, nxt_ver;
    logic [4:0] nxt_alt_ref;
    logic [4:0] qual_idx;
    logic [7:0] nxt_qual;

    always_comb begin
        nxt_sw = pedu_pkg::SW_OK;
        we_pin_cnt = 1'b0;
        we_unl_cnt = 1'b0;
        we_en = 1'b0;
        we_pin_val = 1'b0;
        we_alt = 1'b0;
        we_qual = 1'b0;
        we_ver = 1'b0;
        nxt_pin_cnt = cur_pin_cnt;
        nxt_unl_cnt = cur_unl_cnt;
        nxt_en = cur_en;
        nxt_alt_on = cur_alt_on;
        nxt_alt_ref = cur_alt_ref;
        nxt_ver = cur_ver;
        qual_idx = cur_alt_ref;
        nxt_qual = pedu_pkg::QUAL_NOUSE;
        if (!(is_dis || is_en || is_unb)) begin
            nxt_sw = pedu_pkg::SW_INS;
        end else if (!p1_ok || !p2_ok) begin
            nxt_sw = pedu_pkg::SW_P1P2;
        end else if (!lc_ok) begin
            nxt_sw = pedu_pkg::SW_LEN;
        end else if (is_dis || is_en) begin
            if ((is_dis && !cur_en) || (is_en && cur_en) || pin_blk) begin
                nxt_sw = pedu_pkg::SW_REFUSED;
            end else if (pin_match) begin
                we_pin_cnt = 1'b1;
                nxt_pin_cnt = pedu_pkg::PIN_CNT_INIT;
                we_en = 1'b1;
                nxt_en = is_en;
                if (is_dis && p1_alt) begin
                    we_alt = 1'b1;
                    nxt_alt_on = 1'b1;
                    nxt_alt_ref = p1_ref;
                    we_qual = 1'b1;
                    qual_idx = p1_ref;
                    nxt_qual = pedu_pkg::QUAL_USE;
                end else if (is_en && cur_alt_on) begin
                    we_alt = 1'b1;
                    nxt_alt_on = 1'b0;
                    we_qual = 1'b1;
                    nxt_qual = pedu_pkg::QUAL_NOUSE;
                end
            end else begin
                we_pin_cnt = 1'b1;
                nxt_pin_cnt = dec_pin;
                we_ver = 1'b1;
                nxt_ver = 1'b0;
                nxt_sw = {pedu_pkg::SW_RETRY, 2'h0, dec_pin};
                if (is_en && dec_pin == 2'h0 && ENABLE_ON_BLOCK) begin
                    we_en = 1'b1;
                    nxt_en = 1'b1;
                end
            end
        end else if (lc_empty) begin
            nxt_sw = {pedu_pkg::SW_RETRY, cur_unl_cnt};
        end else if (unl_blk) begin
            nxt_sw = pedu_pkg::SW_BLOCKED;
        end else if (unl_match) begin
            we_pin_val = 1'b1;
            we_unl_cnt = 1'b1;
            nxt_unl_cnt = pedu_pkg::UNL_CNT_INIT;
            we_pin_cnt = 1'b1;
            nxt_pin_cnt = pedu_pkg::PIN_CNT_INIT;
            we_en = 1'b1;
            nxt_en = 1'b1;
            we_ver = 1'b1;
            nxt_ver = 1'b1;
        end else begin
            we_unl_cnt = 1'b1;
            nxt_unl_cnt = dec_unl;
            nxt_sw = {pedu_pkg::SW_RETRY, dec_unl};
        end
    end

    // ------------------------------------------------------------
    // Per-slot storage
    // ------------------------------------------------------------
    // Values and counters carry no reset so that they model retained
    // storage across sessions; only the session's verified flag clears.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOT; gi++) begin : g_slot
            logic [1:0] pin_cnt_ff;
            logic [3:0] unl_cnt_ff;
            logic en_ff;
            logic ver_ff;
            logic alt_on_ff;
            logic [4:0] alt_ref_ff;
            logic [63:0] pin_ff;
            logic [63:0] unl_ff;
            wire hit = CMD_VALID_I && slot == SLOT_W'(gi);
            wire reg_hit = reg_slot == SLOT_W'(gi);

            always_ff @(posedge MCLK_I) begin
                if (perso) begin
                    pin_cnt_ff <= pedu_pkg::PIN_CNT_INIT;
                    unl_cnt_ff <= pedu_pkg::UNL_CNT_INIT;
                    en_ff <= 1'b1;
                    alt_on_ff <= 1'b0;
                    alt_ref_ff <= 5'h00;
                end else if (hit) begin
                    if (we_pin_cnt) pin_cnt_ff <= nxt_pin_cnt;
                    if (we_unl_cnt) unl_cnt_ff <= nxt_unl_cnt;
                    if (we_en) en_ff <= nxt_en;
                    if (we_alt) alt_on_ff <= nxt_alt_on;
                    if (we_alt) alt_ref_ff <= nxt_alt_ref;
                end
            end

            always_ff @(posedge MCLK_I) begin
                if (hit && we_pin_val) begin
                    pin_ff <= new_pin;
                end else if (load_pin && reg_hit) begin
                    pin_ff <= load_val;
                end
                if (load_unl && reg_hit) begin
                    unl_ff <= load_val;
                end
            end

            always_ff @(posedge MCLK_I or negedge RESETN_I) begin
                if (!RESETN_I) begin
                    ver_ff <= 1'b0;
                end else if (hit && we_ver) begin
                    ver_ff <= nxt_ver;
                end
            end

            assign pin_cnt_w[gi] = pin_cnt_ff;
            assign unl_cnt_w[gi] = unl_cnt_ff;
            assign en_w[gi] = en_ff;
            assign ver_w[gi] = ver_ff;
            assign alt_on_w[gi] = alt_on_ff;
            assign alt_ref_w[gi] = alt_ref_ff;
            assign pin_w[gi] = pin_ff;
            assign unl_w[gi] = unl_ff;
            // Disabled without replacement grants even when blocked; enabled needs verification
            assign ACCESS_OK_O[gi] = (!en_ff && !alt_on_ff)
                                   || (en_ff && pin_cnt_ff != 2'h0 && ver_ff);
            assign ALT_REQ_O[gi] = !en_ff && alt_on_ff;
        end
    endgenerate

    // Replacement key usage qualifiers, indexed by global reference
    always_ff @(posedge MCLK_I) begin
        if (perso) begin
            for (int k = 0; k < 32; k++) begin
                qual_ff[k] <= pedu_pkg::QUAL_NOUSE;
            end
        end else if (CMD_VALID_I && we_qual) begin
            qual_ff[qual_idx] <= nxt_qual;
        end
    end

    // ------------------------------------------------------------
    // Response and register file
    // ------------------------------------------------------------
    always_comb begin
        st_word = 32'h0000_0000;
        st_word[pedu_pkg::ST_PIN_CNT_LSB +: 2] = pin_cnt_w[reg_slot];
        st_word[pedu_pkg::ST_UNL_CNT_LSB +: 4] = unl_cnt_w[reg_slot];
        st_word[pedu_pkg::ST_EN_BIT] = en_w[reg_slot];
        st_word[pedu_pkg::ST_VER_BIT] = ver_w[reg_slot];
        st_word[pedu_pkg::ST_ALT_BIT] = alt_on_w[reg_slot];
        st_word[pedu_pkg::ST_ALTREF_LSB +: 5] = alt_ref_w[reg_slot];
    end

    // Key staging registers read back as zero so secrets never leak
    always_comb begin
        case (REG_I.addr)
            pedu_pkg::REG_SLOT: nxt_rdata = {27'h0, slot_sel_ff};
            pedu_pkg::REG_STATUS: nxt_rdata = st_word;
            pedu_pkg::REG_LAST_SW: nxt_rdata = {16'h0, last_sw_ff};
            pedu_pkg::REG_QUAL: nxt_rdata = {24'h0, qual_ff[slot_sel_ff]};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            slot_sel_ff <= pedu_pkg::SLOT_RST;
            val_hi_ff <= pedu_pkg::VAL_RST;
            val_lo_ff <= pedu_pkg::VAL_RST;
        end else if (REG_I.wr) begin
            if (REG_I.addr == pedu_pkg::REG_SLOT) slot_sel_ff <= REG_I.wdata[4:0];
            if (REG_I.addr == pedu_pkg::REG_VAL_HI) val_hi_ff <= REG_I.wdata;
            if (REG_I.addr == pedu_pkg::REG_VAL_LO) val_lo_ff <= REG_I.wdata;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_ff <= 32'h0000_0000;
            rsp_valid_ff <= 1'b0;
            rsp_sw_ff <= pedu_pkg::LAST_SW_RST;
            last_sw_ff <= pedu_pkg::LAST_SW_RST;
        end else begin
            rdata_ff <= REG_I.rd ? nxt_rdata : 32'h0000_0000;
            rsp_valid_ff <= CMD_VALID_I;
            rsp_sw_ff <= CMD_VALID_I ? nxt_sw : rsp_sw_ff;
            last_sw_ff <= CMD_VALID_I ? nxt_sw : last_sw_ff;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign RSP_VALID_O = rsp_valid_ff;
    assign RSP_SW_O = rsp_sw_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire ok_args = CMD_VALID_I && p1_ok && p2_ok && lc_ok;
    wire pin_try = ok_args && (is_dis ? cur_en : is_en && !cur_en) && !pin_blk;
    wire unl_try = ok_args && is_unb && !lc_empty && !unl_blk;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);

    AST_DIS_OK: assert property (pin_try && is_dis && pin_match |=>
        !en_w[$past(slot)] && pin_cnt_w[$past(slot)] == 2'h3 && RSP_SW_O == 16'h9000)
        else $error("Correct disable did not reload and disable");
    AST_DIS_BAD: assert property (pin_try && is_dis && !pin_match && cur_pin_cnt > 2'h1 |=>
        en_w[$past(slot)] && pin_cnt_w[$past(slot)] == $past(cur_pin_cnt) - 2'h1)
        else $error("Wrong disable did not decrement");
    AST_BLOCK: assert property (pin_try && !pin_match && cur_pin_cnt == 2'h1 |=>
        pin_cnt_w[$past(slot)] == 2'h0 && RSP_SW_O == 16'h63c0)
        else $error("Third failure did not block");
    AST_DIS_REF: assert property (ok_args && is_dis && (!cur_en || pin_blk) |=>
        RSP_SW_O == 16'h6985 && pin_cnt_w[$past(slot)] == $past(cur_pin_cnt))
        else $error("Disable not refused");
    AST_EN_REF: assert property (ok_args && is_en && (cur_en || pin_blk) |=>
        RSP_VALID_O && RSP_SW_O == 16'h6985)
        else $error("Enable not refused");
    AST_EN_OK: assert property (pin_try && is_en && pin_match && cur_alt_on |=>
        en_w[$past(slot)] && qual_ff[$past(cur_alt_ref)] == 8'h00 && !alt_on_w[$past(slot)])
        else $error("Enable did not cancel replacement");
    AST_UNB_OK: assert property (unl_try && unl_match |=>
        unl_cnt_w[$past(slot)] == 4'ha && pin_cnt_w[$past(slot)] == 2'h3
        && en_w[$past(slot)] && ACCESS_OK_O[$past(slot)])
        else $error("Unblock did not reload");
    AST_UNB_BAD: assert property (unl_try && !unl_match |=>
        RSP_SW_O == {12'h63c, $past(cur_unl_cnt) - 4'h1}
        && pin_cnt_w[$past(slot)] == $past(cur_pin_cnt))
        else $error("Wrong unblock status or PIN touched");
    AST_UNB_BLK: assert property (ok_args && is_unb && !lc_empty && unl_blk |=>
        RSP_SW_O == 16'h6983)
        else $error("Blocked unblock key not reported");
    AST_QUERY: assert property (ok_args && is_unb && lc_empty |=>
        RSP_SW_O == {12'h63c, $past(cur_unl_cnt)})
        else $error("Retry query wrong");

endmodule

// File: tb/pedu_term.sv
`timescale 1ns/1ns
// ----------------------------------
// Terminal side of the command port
// ----------------------------------
module pedu_term (
    // Clock
    input wire logic clk_i,
    // Frame to the card
    output logic cmd_valid_o,
    output pedu_pkg::pedu_cmd_t cmd_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // Empty Lc re-inverts the idle bus data, so it resends the previous frame's data
    task automatic send(input pedu_pkg::pedu_ins_t ins, input logic [7:0] p1,
            input logic [7:0] p2, input logic [7:0] lc, input logic [127:0] d);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= '{ins, p1, p2, lc, (lc == 8'h00) ? ~cmd_o.data : d};
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o.data <= ~cmd_o.data;
    endtask
endmodule

// File: tb/tb_pin_enable_disable_unblock_logic.sv
`timescale 1ns/1ns
module tb_pin_enable_disable_unblock_logic;
    logic MCLK_I = 1'b0;
    logic RESETN_I = 1'b0;
    pedu_pkg::pedu_reg_req_t reg_req = '0;
    logic [31:0] rdata, rd_v;
    logic cmd_valid, rsp_valid;
    pedu_pkg::pedu_cmd_t cmd;
    logic [15:0] rsp_sw, last_e;
    logic [3:0] acc_ok, alt_req;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [63:0] pin [4], puk [4];
    int pcnt [4] = '{3, 3, 3, 3};
    int ucnt [4] = '{10, 10, 10, 10};
    int aref [4];
    bit en [4] = '{1, 1, 1, 1};
    bit ver [4], alt [4];
    logic [7:0] qual [32] = '{default: 8'h00};

    always #10 MCLK_I = ~MCLK_I;
    pedu_term pedu_term_inst (.clk_i(MCLK_I), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
    pedu_core pedu_core_inst (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .REG_I(reg_req),
        .REG_RDATA_O(rdata), .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .RSP_VALID_O(rsp_valid),
        .RSP_SW_O(rsp_sw), .ACCESS_OK_O(acc_ok), .ALT_REQ_O(alt_req));

    // ----------------------------------
    // Checking
    // ----------------------------------
    task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic cmp_sw(input logic [15:0] got, input logic [15:0] exp);
        note(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        note(got === exp, got, exp);
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        note(got === exp, 32'(got), 32'(exp));
    endtask
    task automatic conclude;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // ----------------------------------
    // Register port and reference model
    // ----------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge MCLK_I);
        reg_req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK_I);
        reg_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge MCLK_I);
        reg_req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [15:0] model(input int k, input logic [7:0] p1, input int s,
            input logic [7:0] lc, input logic [127:0] d);
        logic hit;
        hit = (k == 2) ? d[127:64] == puk[s] : d[127:64] == pin[s];
        if (k == 3) return 16'h6d00;
        if (k == 1 && p1 != 8'h00) return 16'h6a86;
        if (k == 0 && p1 != 8'h00 && !(p1[7] && p1[6:5] == 2'h0 && p1[4:0] != 5'h00))
            return 16'h6a86;
        if (s > 3) return 16'h6a86;
        if (k == 2 && lc == 8'h00) return {12'h63c, 4'(ucnt[s])};
        if (lc != ((k == 2) ? 8'h10 : 8'h08)) return 16'h6700;
        if (k == 2 && ucnt[s] == 0) return 16'h6983;
        if (k < 2 && (pcnt[s] == 0 || en[s] != (k == 0))) return 16'h6985;
        if (!hit) begin
            if (k == 2) ucnt[s]--;
            else pcnt[s]--;
            ver[s] = (k == 2) && ver[s];
            return {12'h63c, 4'((k == 2) ? ucnt[s] : pcnt[s])};
        end
        pcnt[s] = 3;
        en[s] = (k != 0);
        if (k == 2) begin
            pin[s] = d[63:0];
            ucnt[s] = 10;
            ver[s] = 1'b1;
        end
        if (k == 1 && alt[s]) qual[aref[s]] = 8'h00;
        if (k == 0 && p1[7]) qual[p1[4:0]] = 8'h08;
        if (k == 0) aref[s] = int'(p1[4:0]);
        if (k != 2) alt[s] = (k == 0) && p1[7];
        return 16'h9000;
    endfunction
    task automatic do_cmd(input int k, input logic [7:0] p1, input int s, input logic [7:0] lc,
            input logic [127:0] d);
        last_e = model(k, p1, s, lc, d);
        pedu_term_inst.send(pedu_pkg::pedu_ins_t'(k), p1, 8'h04 | 8'(s), lc, d);
        #1 cmp_flag(rsp_valid, 1'b1);
        cmp_sw(rsp_sw, last_e);
        for (int i = 0; i < 4; i++) begin
            cmp_flag(acc_ok[i], en[i] ? ver[i] && pcnt[i] != 0 : !alt[i]);
            cmp_flag(alt_req[i], alt[i] && !en[i]);
        end
    endtask
    task automatic chk_stat(input int s);
        reg_wr(pedu_pkg::REG_SLOT, 32'(s));
        reg_rd(pedu_pkg::REG_STATUS, rd_v);
        cmp_rd(rd_v & 32'h1ff, {23'h0, alt[s], ver[s], en[s], 4'(ucnt[s]), 2'(pcnt[s])});
        cmp_flag(rsp_valid, 1'b0);
    endtask

    // ----------------------------------
    // Scenarios
    // ----------------------------------
    initial begin
        logic [127:0] d;
        int k;
        int s;
        void'($urandom(32'hca936af6));
        repeat (3) @(posedge MCLK_I);
        RESETN_I <= 1'b1;
        reg_rd(pedu_pkg::REG_LAST_SW, rd_v);
        cmp_rd(rd_v, 32'h0);
        reg_wr(pedu_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            pin[i] = {$urandom, $urandom};
            puk[i] = {$urandom, $urandom};
            reg_wr(pedu_pkg::REG_SLOT, 32'(i));
            reg_wr(pedu_pkg::REG_VAL_HI, pin[i][63:32]);
            reg_wr(pedu_pkg::REG_VAL_LO, pin[i][31:0]);
            reg_wr(pedu_pkg::REG_CTRL, 32'h2);
            reg_wr(pedu_pkg::REG_VAL_HI, puk[i][63:32]);
            reg_wr(pedu_pkg::REG_VAL_LO, puk[i][31:0]);
            reg_wr(pedu_pkg::REG_CTRL, 32'h4);
            chk_stat(i);
        end
        do_cmd(3, 8'h00, 0, 8'h08, {pin[0], 64'h0});
        do_cmd(1, 8'h01, 0, 8'h08, {pin[0], 64'h0});
        do_cmd(0, 8'h00, 0, 8'h07, {pin[0], 64'h0});
        do_cmd(0, 8'h80, 0, 8'h08, {pin[0], 64'h0});
        do_cmd(0, 8'hc5, 0, 8'h08, {pin[0], 64'h0});
        do_cmd(1, 8'h00, 32, 8'h08, {pin[0], 64'h0});
        do_cmd(1, 8'h00, 2, 8'h08, {pin[2], 64'h0});
        do_cmd(0, 8'h85, 2, 8'h08, {pin[2], 64'h0});
        do_cmd(0, 8'h00, 2, 8'h08, {pin[2], 64'h0});
        reg_wr(pedu_pkg::REG_SLOT, 32'h5);
        reg_rd(pedu_pkg::REG_QUAL, rd_v);
        cmp_rd(rd_v, {24'h0, qual[5]});
        do_cmd(1, 8'h00, 2, 8'h08, {pin[2], 64'h0});
        reg_rd(pedu_pkg::REG_QUAL, rd_v);
        cmp_rd(rd_v, {24'h0, qual[5]});
        reg_rd(8'h1c, rd_v);
        cmp_rd(rd_v, 32'h0);
        reg_rd(pedu_pkg::REG_CTRL, rd_v);
        cmp_rd(rd_v, 32'h0);
        // Ten wrong keys, one more attempt, then an empty query
        for (int i = 0; i < 12; i++) begin
            do_cmd(2, 8'h00, 3, (i == 11) ? 8'h00 : 8'h10, ~{puk[3], 64'h0});
        end
        // Retained counters survive a reset; session flags, the last status word, slot select and key staging registers clear
        @(posedge MCLK_I);
        RESETN_I <= 1'b0;
        repeat (3) @(posedge MCLK_I);
        RESETN_I <= 1'b1;
        ver = '{default: 1'b0};
        reg_rd(pedu_pkg::REG_LAST_SW, rd_v);
        cmp_rd(rd_v, 32'h0);
        chk_stat(3);
        repeat (120) begin
            k = $urandom_range(2);
            s = $urandom_range(3);
            d = {(k == 2) ? puk[s] : pin[s], $urandom, $urandom};
            if ($urandom_range(3) == 0) d[127:64] = ~d[127:64];
            do_cmd(k, 8'h00, s, (k != 2) ? 8'h08 : ($urandom_range(3) == 0) ? 8'h00 : 8'h10, d);
            chk_stat(s);
        end
        reg_rd(pedu_pkg::REG_LAST_SW, rd_v);
        cmp_rd(rd_v, {16'h0, last_e});
        conclude();
    end
endmodule
